// ===== hw/dpsc_pin_if.sv
// Interface between the controller core and its pin stage.
`timescale 1ns/10ps
interface dpsc_pin_if;
    import dpsc_pkg::*;
    logic [PIN_AW-1:0] addr;
    logic [PIN_DW-1:0] wdata;
    logic              ce_n;
    logic              sem_n;
    logic              oe_n;
    logic              rw_n;
    logic              drive;
    logic [PIN_DW-1:0] rdata;
    logic              busy_n;

    modport ctl (output addr, wdata, ce_n, sem_n, oe_n, rw_n, drive, input rdata, busy_n);
    modport phy (input addr, wdata, ce_n, sem_n, oe_n, rw_n, drive, output rdata, busy_n);
endinterface

// ===== hw/dpsc_pin_stage.sv
// Pin stage: registers every port output and synchronises every port input.
`timescale 1ns/10ps
module dpsc_pin_stage (
    // Clock and reset
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    // Core side
    dpsc_pin_if.phy                          pif,
    // Memory port pins
    output logic [dpsc_pkg::PIN_AW-1:0]      pin_addr,
    input  wire logic [dpsc_pkg::PIN_DW-1:0] pin_data_in,
    output logic [dpsc_pkg::PIN_DW-1:0]      pin_data_out,
    output logic                             pin_data_oe,
    output logic                             pin_chip_enable_n,
    output logic                             pin_semaphore_select_n,
    output logic                             pin_output_enable_n,
    output logic                             pin_read_write_n,
    output logic [1:0]                       pin_byte_enable_n,
    input  wire logic                        pin_collision_flag_n
);
    import dpsc_pkg::*;

    logic [PIN_DW-1:0] data_meta_r;
    logic [PIN_DW-1:0] data_sync_r;
    logic              coll_meta_r;
    logic              coll_sync_r;

    // Outputs come from flops so the pins never glitch between states.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_addr               <= ADDR_RST;
            pin_data_out           <= WDATA_RST;
            pin_data_oe            <= 1'b0;
            pin_chip_enable_n      <= 1'b1;
            pin_semaphore_select_n <= 1'b1;
            pin_output_enable_n    <= 1'b1;
            pin_read_write_n       <= 1'b1;
            pin_byte_enable_n      <= 2'h3;
        end else begin
            pin_addr               <= pif.addr;
            pin_data_out           <= pif.wdata;
            pin_data_oe            <= pif.drive;
            pin_chip_enable_n      <= pif.ce_n;
            pin_semaphore_select_n <= pif.sem_n;
            pin_output_enable_n    <= pif.oe_n;
            pin_read_write_n       <= pif.rw_n;
            pin_byte_enable_n      <= {2{pif.ce_n}};
        end
    end

    // Two-flop synchronisers; the first stage feeds only the second.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_meta_r <= WDATA_RST;
            data_sync_r <= WDATA_RST;
            coll_meta_r <= 1'b1;
            coll_sync_r <= 1'b1;
        end else begin
            data_meta_r <= pin_data_in;
            data_sync_r <= data_meta_r;
            coll_meta_r <= pin_collision_flag_n;
            coll_sync_r <= coll_meta_r;
        end
    end

    assign pif.rdata  = data_sync_r;
    assign pif.busy_n = coll_sync_r;
endmodule

// ===== hw/dpsc_pkg.sv
// Shared constants and types for the dual-port semaphore port controller.
package dpsc_pkg;

    // Pin widths of one memory port.
    localparam int PIN_AW = 15;
    localparam int PIN_DW = 16;
    localparam int SEM_IW = 3;

    // Register bus geometry.
    localparam int BUS_AW = 5;
    localparam int BUS_DW = 32;

    // Timing, in nanoseconds and in clock cycles.
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_SETUP_NS    = 100;
    localparam int T_ACCESS_NS   = 200;
    localparam int T_RECOVER_NS  = 100;
    localparam int SYNC_CYCLES   = 3;
    localparam int CNT_W         = 4;
    localparam int SETUP_I   = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCESS_I  = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_I = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [CNT_W-1:0] SETUP_CNT   = CNT_W'((SETUP_I < 1) ? 1 : SETUP_I);
    localparam logic [CNT_W-1:0] WR_CNT      = CNT_W'((ACCESS_I < 1) ? 1 : ACCESS_I);
    localparam logic [CNT_W-1:0] RD_CNT      = CNT_W'(((ACCESS_I < 1) ? 1 : ACCESS_I)
                                                      + SYNC_CYCLES);
    localparam logic [CNT_W-1:0] RECOVER_CNT = CNT_W'((RECOVER_I < 1) ? 1 : RECOVER_I);
    localparam logic [CNT_W-1:0] CNT_LAST    = 4'h1;

    // Register offsets.
    localparam logic [BUS_AW-1:0] OFS_CMD    = 5'h00;
    localparam logic [BUS_AW-1:0] OFS_ADDR   = 5'h04;
    localparam logic [BUS_AW-1:0] OFS_WDATA  = 5'h08;
    localparam logic [BUS_AW-1:0] OFS_RDATA  = 5'h0C;
    localparam logic [BUS_AW-1:0] OFS_STATUS = 5'h10;

    // Status field positions.
    localparam int ST_BUSY    = 0;
    localparam int ST_DONE    = 1;
    localparam int ST_COLL    = 2;
    localparam int ST_WON     = 3;
    localparam int ST_REFUSED = 4;

    // Reset values.
    localparam logic [PIN_AW-1:0] ADDR_RST  = 15'h0000;
    localparam logic [PIN_DW-1:0] WDATA_RST = 16'h0000;

    // Bus responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Commands written to the command register.
    typedef enum logic [2:0] {
        OP_MEM_RD  = 3'h0,
        OP_MEM_WR  = 3'h1,
        OP_SEM_RD  = 3'h2,
        OP_SEM_WR  = 3'h3,
        OP_CLAIM   = 3'h4,
        OP_RELEASE = 3'h5
    } dpsc_op_t;

    // Pin sequencer states.
    typedef enum logic [1:0] {
        S_IDLE    = 2'h0,
        S_SETUP   = 2'h1,
        S_STROBE  = 2'h2,
        S_RECOVER = 2'h3
    } dpsc_state_t;

endpackage

// ===== hw/dpsc_top.sv
// Host controller for one port of a dual-port memory with hardware semaphores.
//
// Contract
// - Cascaded array has exactly one master part.
// - Address and enable settle before write strobe.
// - Semaphore select low picks semaphore space.
// - Zero requests a token, one releases it.
// - Claim by write zero, then read back.
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
module dpsc_top (
    // Clock and reset
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    // AXI4-Lite write channels
    input  wire logic [dpsc_pkg::BUS_AW-1:0] s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [dpsc_pkg::BUS_DW-1:0] s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [dpsc_pkg::BUS_AW-1:0] s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [dpsc_pkg::BUS_DW-1:0]      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    // Memory port pins
    output logic [dpsc_pkg::PIN_AW-1:0]      pin_addr,
    input  wire logic [dpsc_pkg::PIN_DW-1:0] pin_data_in,
    output logic [dpsc_pkg::PIN_DW-1:0]      pin_data_out,
    output logic                             pin_data_oe,
    output logic                             pin_chip_enable_n,
    output logic                             pin_semaphore_select_n,
    output logic                             pin_output_enable_n,
    output logic                             pin_read_write_n,
    output logic [1:0]                       pin_byte_enable_n,
    input  wire logic                        pin_collision_flag_n
);
    import dpsc_pkg::*;

    // Word decode of a byte address, used by both bus directions.
    function automatic logic hits(input logic [BUS_AW-1:0] a, input logic [BUS_AW-1:0] ofs);
        hits = (a[BUS_AW-1:2] == ofs[BUS_AW-1:2]);
    endfunction

    // Commands that touch the semaphore space rather than the array.
    function automatic logic is_sem(input dpsc_op_t op);
        is_sem = (op == OP_SEM_RD) || (op == OP_SEM_WR) || (op == OP_CLAIM)
                 || (op == OP_RELEASE);
    endfunction

    // Commands whose first bus phase is a write.
    function automatic logic is_write(input dpsc_op_t op);
        is_write = (op != OP_MEM_RD) && (op != OP_SEM_RD);
    endfunction

    // Byte-lane merge of a bus write into a stored word.
    function automatic logic [BUS_DW-1:0] merge(input logic [BUS_DW-1:0] old_v,
                                                input logic [BUS_DW-1:0] new_v,
                                                input logic [3:0]        strb);
        logic [BUS_DW-1:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        merge = res;
    endfunction

    dpsc_pin_if pif ();

    logic                 aw_held_r;
    logic [BUS_AW-1:0]    aw_addr_r;
    logic                 w_held_r;
    logic [BUS_DW-1:0]    w_data_r;
    logic [3:0]           w_strb_r;
    logic                 wr_fire;
    logic                 rd_take;
    logic [PIN_AW-1:0]    addr_r;
    logic [PIN_DW-1:0]    wdat_r;
    logic [PIN_DW-1:0]    rdat_r;
    logic                 done_r;
    logic                 coll_r;
    logic                 won_r;
    logic                 refused_r;
    dpsc_op_t             cur_op_r;
    dpsc_op_t             new_op;
    dpsc_state_t          state_r;
    logic [CNT_W-1:0]     cnt_r;
    logic                 rd_phase_r;
    logic                 cmd_hit;
    logic                 op_ok;
    logic                 start;
    logic                 wr_phase;
    logic                 capture;
    logic                 finish;
    logic                 coll_seen;
    logic                 sem_bit;
    logic [BUS_DW-1:0]    status_w;
    logic [BUS_DW-1:0]    clr_w;
    logic                 p_ce_n_r;
    logic                 p_sem_n_r;
    logic                 p_oe_n_r;
    logic                 p_rw_n_r;
    logic                 p_drive_r;
    logic [PIN_AW-1:0]    p_addr_r;
    logic [PIN_DW-1:0]    p_wdata_r;

    // A write completes once both address and data have been taken, in any order.
    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
    assign wr_fire       = aw_held_r && w_held_r;
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_take       = s_axi_arvalid && s_axi_arready;

    // Write address and data holding stages.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= OFS_CMD;
            w_held_r  <= 1'b0;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // Write response; unmapped or read-only words answer with an error.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (hits(aw_addr_r, OFS_CMD) || hits(aw_addr_r, OFS_ADDR)
                             || hits(aw_addr_r, OFS_WDATA) || hits(aw_addr_r, OFS_STATUS))
                            ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Address and data registers that steer the next access.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr_r <= ADDR_RST;
            wdat_r <= WDATA_RST;
        end else if (wr_fire) begin
            if (hits(aw_addr_r, OFS_ADDR)) begin
                addr_r <= PIN_AW'(merge({17'h0_0000, addr_r}, w_data_r, w_strb_r));
            end
            if (hits(aw_addr_r, OFS_WDATA)) begin
                wdat_r <= PIN_DW'(merge({16'h0000, wdat_r}, w_data_r, w_strb_r));
            end
        end
    end

    // Command acceptance; a command while busy or an unknown code is refused.
    assign new_op   = dpsc_op_t'(w_data_r[2:0]);
    assign cmd_hit  = wr_fire && hits(aw_addr_r, OFS_CMD) && w_strb_r[0];
    assign op_ok    = (w_data_r[2:0] <= OP_RELEASE);
    assign start    = cmd_hit && op_ok && (state_r == S_IDLE);
    assign wr_phase = is_write(cur_op_r) && !rd_phase_r;
    assign capture  = (state_r == S_STROBE) && (cnt_r == CNT_LAST) && !wr_phase;
    assign finish   = (state_r == S_RECOVER) && (cnt_r == CNT_LAST)
                      && !((cur_op_r == OP_CLAIM) && !rd_phase_r);
    // Collision is only meaningful for array accesses, never for semaphores.
    assign coll_seen = (state_r == S_STROBE) && !is_sem(cur_op_r) && !pif.busy_n;
    // Claim writes zero, release writes one, plain writes take data bit zero.
    assign sem_bit  = (new_op == OP_CLAIM) ? 1'b0 :
                      (new_op == OP_RELEASE) ? 1'b1 : wdat_r[0];

    // Pin sequencer: select, settle, strobe, deselect.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r    <= S_IDLE;
            cnt_r      <= SETUP_CNT;
            rd_phase_r <= 1'b0;
            cur_op_r   <= OP_MEM_RD;
            p_ce_n_r   <= 1'b1;
            p_sem_n_r  <= 1'b1;
            p_oe_n_r   <= 1'b1;
            p_rw_n_r   <= 1'b1;
            p_drive_r  <= 1'b0;
            p_addr_r   <= ADDR_RST;
            p_wdata_r  <= WDATA_RST;
        end else begin
            case (state_r)
                S_IDLE: begin
                    if (start) begin
                        cur_op_r   <= new_op;
                        rd_phase_r <= 1'b0;
                        p_ce_n_r   <= is_sem(new_op);
                        p_sem_n_r  <= !is_sem(new_op);
                        // Only the latch index reaches the pins in semaphore space.
                        p_addr_r   <= is_sem(new_op) ? {12'h000, addr_r[SEM_IW-1:0]}
                                                     : addr_r;
                        p_wdata_r  <= is_sem(new_op) ? {PIN_DW{sem_bit}} : wdat_r;
                        cnt_r      <= SETUP_CNT;
                        state_r    <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    // Address and select settle before any strobe starts.
                    if (cnt_r == CNT_LAST) begin
                        p_rw_n_r  <= !wr_phase;
                        p_drive_r <= wr_phase;
                        p_oe_n_r  <= wr_phase;
                        cnt_r     <= wr_phase ? WR_CNT : RD_CNT;
                        state_r   <= S_STROBE;
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                S_STROBE: begin
                    if (cnt_r == CNT_LAST) begin
                        // Dropping both selects ends the access and lets the
                        // part fall to standby; the next read re-latches.
                        p_rw_n_r  <= 1'b1;
                        p_oe_n_r  <= 1'b1;
                        p_ce_n_r  <= 1'b1;
                        p_sem_n_r <= 1'b1;
                        cnt_r     <= RECOVER_CNT;
                        state_r   <= S_RECOVER;
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                S_RECOVER: begin
                    if (cnt_r != CNT_LAST) begin
                        cnt_r <= cnt_r - 4'h1;
                    end else if ((cur_op_r == OP_CLAIM) && !rd_phase_r) begin
                        // Claim reads back after its zero write.
                        rd_phase_r <= 1'b1;
                        p_drive_r  <= 1'b0;
                        p_sem_n_r  <= 1'b0;
                        cnt_r      <= SETUP_CNT;
                        state_r    <= S_SETUP;
                    end else begin
                        p_drive_r <= 1'b0;
                        state_r   <= S_IDLE;
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

    // Read capture; a semaphore flag arrives replicated, so bit zero is enough.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdat_r <= WDATA_RST;
            won_r  <= 1'b0;
        end else if (capture) begin
            rdat_r <= pif.rdata;
            if (cur_op_r == OP_CLAIM) begin
                won_r <= !pif.rdata[0];
            end
        end
    end

    // Sticky status bits: hardware set wins over a same-cycle clear.
    assign clr_w = (wr_fire && hits(aw_addr_r, OFS_STATUS)) ? merge(32'h0000_0000, w_data_r,
                                                                    w_strb_r) : 32'h0000_0000;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_r    <= 1'b0;
            coll_r    <= 1'b0;
            refused_r <= 1'b0;
        end else begin
            done_r    <= finish || (done_r && !clr_w[ST_DONE]);
            coll_r    <= coll_seen || (coll_r && !clr_w[ST_COLL]);
            refused_r <= (cmd_hit && !start) || (refused_r && !clr_w[ST_REFUSED]);
        end
    end

    // Read channel.
    always_comb begin
        status_w             = 32'h0000_0000;
        status_w[ST_BUSY]    = (state_r != S_IDLE);
        status_w[ST_DONE]    = done_r;
        status_w[ST_COLL]    = coll_r;
        status_w[ST_WON]     = won_r;
        status_w[ST_REFUSED] = refused_r;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            if (hits(s_axi_araddr, OFS_CMD)) begin
                s_axi_rdata <= {29'h0000_0000, cur_op_r};
            end else if (hits(s_axi_araddr, OFS_ADDR)) begin
                s_axi_rdata <= {17'h0_0000, addr_r};
            end else if (hits(s_axi_araddr, OFS_WDATA)) begin
                s_axi_rdata <= {16'h0000, wdat_r};
            end else if (hits(s_axi_araddr, OFS_RDATA)) begin
                s_axi_rdata <= {16'h0000, rdat_r};
            end else if (hits(s_axi_araddr, OFS_STATUS)) begin
                s_axi_rdata <= status_w;
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Core drives toward the pin stage.
    assign pif.addr  = p_addr_r;
    assign pif.wdata = p_wdata_r;
    assign pif.ce_n  = p_ce_n_r;
    assign pif.sem_n = p_sem_n_r;
    assign pif.oe_n  = p_oe_n_r;
    assign pif.rw_n  = p_rw_n_r;
    assign pif.drive = p_drive_r;

    dpsc_pin_stage u_pins (
        .aclk                   (aclk),
        .aresetn                (aresetn),
        .pif                    (pif.phy),
        .pin_addr               (pin_addr),
        .pin_data_in            (pin_data_in),
        .pin_data_out           (pin_data_out),
        .pin_data_oe            (pin_data_oe),
        .pin_chip_enable_n      (pin_chip_enable_n),
        .pin_semaphore_select_n (pin_semaphore_select_n),
        .pin_output_enable_n    (pin_output_enable_n),
        .pin_read_write_n       (pin_read_write_n),
        .pin_byte_enable_n      (pin_byte_enable_n),
        .pin_collision_flag_n   (pin_collision_flag_n)
    );
endmodule

// ===== verif/dpsc_dev_model.sv
// Behavioural model of one memory port with its eight semaphore latches.
`timescale 1ns/10ps
module dpsc_dev_model (
    // Pins of this port
    input  wire logic [14:0] pin_addr,
    input  wire logic [15:0] pin_data_out,
    input  wire logic        pin_chip_enable_n,
    input  wire logic        pin_semaphore_select_n,
    input  wire logic        pin_output_enable_n,
    input  wire logic        pin_read_write_n,
    input  wire logic        pin_collision_flag_n,
    output logic      [15:0] pin_data_in
);
    logic [7:0]  mine   = 8'h00;
    logic [7:0]  theirs = 8'h80; // The far side already holds latch seven.
    logic [15:0] mem [8];
    logic [15:0] q      = 16'hA5A5;
    // Writes land at the falling strobe, when index and data are already set.
    always @(negedge pin_read_write_n) begin
        if (!pin_semaphore_select_n) begin
            if (!pin_data_out[0]) mine[pin_addr[2:0]] |= !theirs[pin_addr[2:0]];
            else mine[pin_addr[2:0]] = 1'b0;
        end else if (!pin_chip_enable_n && pin_collision_flag_n) begin
            mem[pin_addr[2:0]] = pin_data_out;
        end
    end
    // The read value is frozen when the strobe falls, so a late flip is not seen.
    always @(negedge pin_output_enable_n)
        q = !pin_semaphore_select_n ? {16{!mine[pin_addr[2:0]]}} : mem[pin_addr[2:0]];
    // Released lines show the inverse, so a late sample cannot pass.
    assign pin_data_in = pin_output_enable_n ? ~q : q;
endmodule

// ===== verif/dpsc_top_asserts.sv
// Pin sequencing assertions for the semaphore port controller.
`timescale 1ns/10ps
module dpsc_asserts (
    // Watched ports
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        pin_chip_enable_n,
    input wire logic        pin_semaphore_select_n,
    input wire logic        pin_output_enable_n,
    input wire logic        pin_read_write_n,
    input wire logic        pin_data_oe,
    input wire logic [1:0]  pin_byte_enable_n,
    input wire logic [14:0] pin_addr,
    input wire logic [15:0] pin_data_out
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_space; !(!pin_chip_enable_n && !pin_semaphore_select_n); endproperty
    a_space: assert property (p_space) else $error("two spaces selected");
    property p_excl; !pin_read_write_n |-> pin_output_enable_n; endproperty
    a_excl: assert property (p_excl) else $error("read and write strobes");
    property p_wlen; $fell(pin_read_write_n) |=> !pin_read_write_n ##1 pin_read_write_n; endproperty
    a_wlen: assert property (p_wlen) else $error("write strobe length");
    property p_setup;
        $fell(pin_read_write_n) |-> !($past(pin_chip_enable_n) && $past(pin_semaphore_select_n));
    endproperty
    a_setup: assert property (p_setup) else $error("strobe without setup");
    property p_hold; !pin_read_write_n |-> $stable(pin_addr); endproperty
    a_hold: assert property (p_hold) else $error("address moved in strobe");
    property p_idx; !pin_semaphore_select_n |-> pin_addr[14:3] == 12'h000; endproperty
    a_idx: assert property (p_idx) else $error("upper index bits set");
    property p_bit; !pin_semaphore_select_n && !pin_read_write_n |->
        pin_data_out == {16{pin_data_out[0]}}; endproperty
    a_bit: assert property (p_bit) else $error("flag not on all bits");
    property p_rlen; $fell(pin_output_enable_n) |=> !pin_output_enable_n[*4] ##1 pin_output_enable_n;
    endproperty
    a_rlen: assert property (p_rlen) else $error("read strobe length");
    property p_drv; !pin_read_write_n |->
        pin_data_oe && pin_byte_enable_n == {2{pin_chip_enable_n}}; endproperty
    a_drv: assert property (p_drv) else $error("lanes idle in write");
endmodule
bind dpsc_top dpsc_asserts u_asserts (.aclk, .aresetn, .pin_chip_enable_n,
    .pin_semaphore_select_n, .pin_output_enable_n, .pin_read_write_n, .pin_addr, .pin_data_out,
    .pin_data_oe, .pin_byte_enable_n);

// ===== verif/dpsc_top_bench.sv
// Self-checking bench for the semaphore port controller.
`timescale 1ns/10ps
module dpsc_top_bench;
    import dpsc_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic pin_collision_flag_n = 1'b1;
    logic [BUS_AW-1:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [BUS_DW-1:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp, pin_byte_enable_n;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pin_data_oe;
    logic pin_chip_enable_n, pin_semaphore_select_n, pin_output_enable_n, pin_read_write_n;
    logic [PIN_AW-1:0] pin_addr;
    logic [PIN_DW-1:0] pin_data_in, pin_data_out;
    int miscompares = 0, n_compared = 0, cyc = 0;
    dpsc_top u_dut (.*);
    dpsc_dev_model u_dev (.*);
    always #50 aclk = ~aclk;
    // The whole sequence needs well under a thousand cycles.
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Each channel holds its payload until its own ready is seen at an edge.
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rsp = s_axi_bresp;
    endtask
    task automatic rdr(input logic [4:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask
    // Run one pin command, wait for done, clear done and leave the status in rd.
    task automatic cmd(input logic [14:0] a, input logic [15:0] d, input dpsc_op_t op);
        wr(OFS_ADDR, 32'(a));
        wr(OFS_WDATA, 32'(d));
        wr(OFS_CMD, 32'(op));
        do rdr(OFS_STATUS); while (rd[ST_DONE] !== 1'b1);
        wr(OFS_STATUS, 32'h2);
    endtask
    task automatic semaphore_select_n(input logic [2:0] i, input logic [31:0] exp);
        cmd(15'(i), 16'h0, OP_SEM_RD);
        rdr(OFS_RDATA);
        chk("flag", rd, exp);
    endtask
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        cmd(15'h7FF2, 16'h0, OP_CLAIM);
        chk("won free", 32'(rd[ST_WON]), 32'h1);
        cmd(15'h0007, 16'h0, OP_CLAIM);
        chk("won held", 32'(rd[ST_WON]), 32'h0);
        semaphore_select_n(3'h2, 32'h0);
        cmd(15'h0002, 16'h0, OP_RELEASE);
        semaphore_select_n(3'h2, 32'hFFFF);
        cmd(15'h0003, 16'hFFFE, OP_SEM_WR);
        semaphore_select_n(3'h3, 32'h0);
        cmd(15'h0005, 16'h5AC3, OP_MEM_WR);
        cmd(15'h0005, 16'h0, OP_MEM_RD);
        rdr(OFS_RDATA);
        chk("memory", rd, 32'h5AC3);
        pin_collision_flag_n <= 1'b0;
        cmd(15'h0006, 16'h1234, OP_MEM_WR);
        chk("collision", 32'(rd[ST_COLL]), 32'h1);
        pin_collision_flag_n <= 1'b1;
        wr(OFS_RDATA, 32'h0);
        chk("read-only", 32'(rsp), 32'(RESP_SLVERR));
        rdr(5'h14);
        chk("unmapped", 32'(rsp), 32'(RESP_SLVERR));
        conclude();
    end
endmodule
